// *** bcs_pkg.sv ***
// bcs_pkg: constants and types for the bcd clock sram port
// assumes a 100 MHz model clock
package bcs_pkg;
  localparam int          CLK_MHZ          = 100;
  localparam int          ADDR_W           = 13;
  localparam int          DATA_W           = 8;
  localparam int          MEM_DEPTH        = 8192;
  localparam logic [12:0] OFS_CONTROL      = 13'h1FF8;
  localparam logic [12:0] OFS_SECONDS      = 13'h1FF9;
  localparam logic [12:0] OFS_MINUTES      = 13'h1FFA;
  localparam logic [12:0] OFS_HOURS        = 13'h1FFB;
  localparam logic [12:0] OFS_WEEKDAY      = 13'h1FFC;
  localparam logic [12:0] OFS_DATE         = 13'h1FFD;
  localparam logic [12:0] OFS_MONTH        = 13'h1FFE;
  localparam logic [12:0] OFS_YEAR         = 13'h1FFF;
  localparam int          CTL_WRITE_BIT    = 7;
  localparam int          CTL_READ_BIT     = 6;
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  // times in ns, ms and us
  localparam int LOCATION_ACCESS_NS = 70;
  localparam int SELECT_ACCESS_NS   = 70;
  localparam int DRIVE_ACCESS_NS    = 35;
  localparam int OUTPUT_HOLD_NS     = 10;
  localparam int RECOVERY_MIN_MS    = 40;
  localparam int RECOVERY_MAX_MS    = 200;
  localparam int RECOVERY_IND_MS    = 20;
  localparam int FALL_DELAY_US      = 200;
  // least times round up
  localparam int LOCATION_ACCESS_CYC = (LOCATION_ACCESS_NS*CLK_MHZ+999)/1000;
  localparam int SELECT_ACCESS_CYC   = (SELECT_ACCESS_NS*CLK_MHZ+999)/1000;
  localparam int DRIVE_ACCESS_CYC    = (DRIVE_ACCESS_NS*CLK_MHZ+999)/1000;
  // hold is a minimum of valid data: round down, at least one
  localparam int OUTPUT_HOLD_CYC     = (OUTPUT_HOLD_NS*CLK_MHZ)/1000 < 1 ? 1 :
                                       (OUTPUT_HOLD_NS*CLK_MHZ)/1000;
  localparam int RECOVERY_CYC        = RECOVERY_MIN_MS*CLK_MHZ*1000;
  localparam int SECOND_CYC          = CLK_MHZ*1000000;
  localparam int CNT_W               = 32;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } bcs_time_s;
endpackage : bcs_pkg

// *** bcs_clock_sram.sv ***
// bcs_clock_sram: 8k x8 sram with bcd clock bytes at the top
// assumes pins reach it raw; byte lines resolved outside
//
// Functional notes
// - clock bytes at top eight locations, bcd
// - date rolls over for all months, leap
// - lowest clock byte is control byte
// - clock bytes refreshed from counters each second
// - clock bytes accessed like any location
// - no writes while supply fails
// - memory and counting survive backup switchover
// - read when write high, select low
// - thirteen lines select one of 8192 bytes
// - data valid after all three access times
// - drive only with select and enable low
// - early enable drives undefined until access
// - address change: hold, then undefined
// - select with write falling: stay undriven
// - reset held 40 to 200 ms after recovery
// - fast fall may delay protection 200 us
// - write while select and write low
// - read bit halts refresh of clock bytes
// - write bit halts; clearing loads counters
`timescale 1ns/1ps
module bcs_clock_sram #(
  parameter int RECOVERY_CYC = bcs_pkg::RECOVERY_CYC,
  parameter int SECOND_CYC   = bcs_pkg::SECOND_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [12:0] location_lines_i,
  input  wire logic [7:0]  byte_lines_i,
  output logic [7:0]       byte_lines_o,
  output logic             byte_lines_oe_n_o,
  input  wire logic        select_n_i,
  input  wire logic        drive_n_i,
  input  wire logic        write_n_i,
  input  wire logic        supply_fail_i,
  input  wire logic        on_backup_i,
  output logic             reset_out_o,
  output logic             reset_out_oe_n_o
);
  localparam logic [7:0] UNDEF = 8'hFF;

  typedef struct packed {
    logic [2:0]  sel_s;
    logic [2:0]  drv_s;
    logic [2:0]  wr_s;
    logic [1:0]  fail_s;
    logic [1:0]  backup_s;
    logic [12:0] addr_s1;
    logic [12:0] addr;
    logic [12:0] addr_prev;
    logic [7:0]  din_s1;
    logic [7:0]  din;
    logic [7:0]  a_cnt;
    logic [7:0]  e_cnt;
    logic [7:0]  g_cnt;
    logic [7:0]  h_cnt;
    logic [7:0]  old_data;
    logic        no_drive;
    logic        in_write;
    logic [31:0] sec_cnt;
    logic [31:0] rec_cnt;
    logic        fail_seen;
    logic        halted;
    logic        load_pend;
    bcs_pkg::bcs_time_s ctr;
    logic [7:0]  dout;
    logic        oe_n;
  } bcs_state_s;

  bcs_state_s r, next_r;
  logic [7:0] mem [0:bcs_pkg::MEM_DEPTH-1];

  // two flop synchroniser for the reset release
  logic [1:0] rst_pipe;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) rst_pipe <= 2'b00;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  wire logic rst_n = rst_pipe[1];

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [7:0] month_days(input logic [7:0] mo,
                                            input logic [7:0] yr);
    logic [6:0] y;
    y = 7'(yr[7:4] * 4'hA) + 7'(yr[3:0]);
    if (mo == 8'h02) month_days = (y[1:0] == 2'b00) ? 8'h29 : 8'h28;
    else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11)
      month_days = 8'h30;
    else month_days = 8'h31;
  endfunction : month_days

  // one second advance of the counters
  function automatic bcs_pkg::bcs_time_s tick(input bcs_pkg::bcs_time_s t);
    bcs_pkg::bcs_time_s n;
    n = t;
    n.sec = bcd_inc(t.sec);
    if (t.sec == 8'h59) begin
      n.sec = 8'h00;
      n.min = bcd_inc(t.min);
      if (t.min == 8'h59) begin
        n.min  = 8'h00;
        n.hour = bcd_inc(t.hour);
        if (t.hour == 8'h23) begin
          n.hour = 8'h00;
          n.wday = (t.wday == 8'h07) ? 8'h01 : t.wday + 8'h01;
          n.date = bcd_inc(t.date);
          if (t.date == month_days(t.month, t.year)) begin
            n.date  = 8'h01;
            n.month = bcd_inc(t.month);
            if (t.month == 8'h12) begin
              n.month = 8'h01;
              n.year  = (t.year == 8'h99) ? 8'h00 : bcd_inc(t.year);
            end
          end
        end
      end
    end
    tick = n;
  endfunction : tick

  logic       sel, drv, wr, fail, wr_fall_with_sel;
  logic       addr_moved;
  logic       do_write, sec_tick, refresh;
  logic [7:0] ctl;
  always_comb begin
    next_r = r;
    sel = !r.sel_s[1];
    drv = !r.drv_s[1];
    wr  = !r.wr_s[1];
    fail = r.fail_s[1];
    ctl = mem[bcs_pkg::OFS_CONTROL];
    // change seen only past the synchroniser, never on its first stage
    addr_moved = (r.addr != r.addr_prev);
    next_r.sel_s  = {r.sel_s[1:0], select_n_i};
    next_r.drv_s  = {r.drv_s[1:0], drive_n_i};
    next_r.wr_s   = {r.wr_s[1:0], write_n_i};
    next_r.fail_s = {r.fail_s[0], supply_fail_i};
    next_r.backup_s = {r.backup_s[0], on_backup_i};
    next_r.addr_s1 = location_lines_i;
    next_r.addr    = r.addr_s1;
    next_r.addr_prev = r.addr;
    next_r.din_s1  = byte_lines_i;
    next_r.din     = r.din_s1;
    // access counters; 8-bit counters saturate at the needed figure, hold counter counts down to zero
    next_r.a_cnt = addr_moved ? 8'h00 :
      (r.a_cnt < 8'(bcs_pkg::LOCATION_ACCESS_CYC) ? r.a_cnt + 8'h01 : r.a_cnt);
    next_r.e_cnt = !sel ? 8'h00 :
      (r.e_cnt < 8'(bcs_pkg::SELECT_ACCESS_CYC) ? r.e_cnt + 8'h01 : r.e_cnt);
    next_r.g_cnt = !(sel && drv) ? 8'h00 :
      (r.g_cnt < 8'(bcs_pkg::DRIVE_ACCESS_CYC) ? r.g_cnt + 8'h01 : r.g_cnt);
    next_r.h_cnt = addr_moved ? 8'(bcs_pkg::OUTPUT_HOLD_CYC) :
      (r.h_cnt != 8'h00 ? r.h_cnt - 8'h01 : 8'h00);
    // select and write falling in the same sample keeps outputs off
    wr_fall_with_sel = r.sel_s[2] && !r.sel_s[1] && r.wr_s[2] && !r.wr_s[1];
    if (!sel) next_r.no_drive = 1'b0;
    else if (wr_fall_with_sel) next_r.no_drive = 1'b1;
    next_r.in_write = sel && wr;
    // write lands at the end of the low overlap (earlier rising edge)
    do_write = r.in_write && !(sel && wr) && !fail && r.rec_cnt == 32'h0 &&
               !r.fail_seen;
    // supply monitor: protect, then hold reset through recovery
    if (fail) begin
      next_r.fail_seen = 1'b1;
      next_r.rec_cnt   = 32'(RECOVERY_CYC);
    end else if (r.rec_cnt != 32'h0) begin
      next_r.rec_cnt = r.rec_cnt - 32'h1;
    end else begin
      next_r.fail_seen = 1'b0;
    end
    // counters keep running on backup; only clearing the write bit loads them from the bytes
    sec_tick = (r.sec_cnt == 32'(SECOND_CYC - 1));
    next_r.sec_cnt = sec_tick ? 32'h0 : r.sec_cnt + 32'h1;
    if (sec_tick) next_r.ctr = tick(r.ctr);
    next_r.halted = ctl[bcs_pkg::CTL_WRITE_BIT] || ctl[bcs_pkg::CTL_READ_BIT];
    // clearing the write bit loads the counters from the bytes
    next_r.load_pend = 1'b0;
    if (r.halted && mem[bcs_pkg::OFS_CONTROL][bcs_pkg::CTL_WRITE_BIT] == 1'b0
        && r.load_pend) begin
      next_r.ctr = {mem[bcs_pkg::OFS_SECONDS] & 8'h7F,
                    mem[bcs_pkg::OFS_MINUTES], mem[bcs_pkg::OFS_HOURS],
                    mem[bcs_pkg::OFS_WEEKDAY] & 8'h07,
                    mem[bcs_pkg::OFS_DATE], mem[bcs_pkg::OFS_MONTH],
                    mem[bcs_pkg::OFS_YEAR]};
      next_r.sec_cnt = 32'h0;
    end
    if (ctl[bcs_pkg::CTL_WRITE_BIT]) next_r.load_pend = 1'b1;
    if (r.load_pend && !ctl[bcs_pkg::CTL_WRITE_BIT]) next_r.load_pend = 1'b1;
    if (r.load_pend && !ctl[bcs_pkg::CTL_WRITE_BIT] && r.halted)
      next_r.load_pend = 1'b0;
    refresh = sec_tick && !next_r.halted;
    // read path: valid only after all three access times
    next_r.oe_n = !(sel && drv && !wr && !r.no_drive) || fail ||
                  r.fail_seen;
    if (!addr_moved && r.a_cnt >= 8'(bcs_pkg::LOCATION_ACCESS_CYC) &&
        r.e_cnt >= 8'(bcs_pkg::SELECT_ACCESS_CYC) &&
        r.g_cnt >= 8'(bcs_pkg::DRIVE_ACCESS_CYC)) begin
      next_r.dout = mem[r.addr];
      next_r.old_data = mem[r.addr];
    end else if (addr_moved || r.h_cnt != 8'h00) begin
      next_r.dout = r.old_data;
    end else begin
      next_r.dout = UNDEF;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.sel_s <= 3'b111;
      r.drv_s <= 3'b111;
      r.wr_s  <= 3'b111;
      r.oe_n  <= 1'b1;
      r.rec_cnt <= 32'(RECOVERY_CYC);
      r.fail_seen <= 1'b1;
      r.ctr <= {8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    end else begin
      r <= next_r;
    end
  end

  // storage array; host write beats the refresh on the same byte
  always_ff @(posedge clock_i) begin
    if (refresh) begin
      mem[bcs_pkg::OFS_SECONDS] <= {mem[bcs_pkg::OFS_SECONDS][7],
                                    next_r.ctr.sec[6:0]};
      mem[bcs_pkg::OFS_MINUTES] <= next_r.ctr.min;
      mem[bcs_pkg::OFS_HOURS]   <= next_r.ctr.hour;
      mem[bcs_pkg::OFS_WEEKDAY] <= {mem[bcs_pkg::OFS_WEEKDAY][7:3],
                                    next_r.ctr.wday[2:0]};
      mem[bcs_pkg::OFS_DATE]    <= next_r.ctr.date;
      mem[bcs_pkg::OFS_MONTH]   <= next_r.ctr.month;
      mem[bcs_pkg::OFS_YEAR]    <= next_r.ctr.year;
    end
    if (do_write) mem[r.addr] <= r.din;
  end

  assign byte_lines_o      = r.dout;
  assign byte_lines_oe_n_o = r.oe_n;
  assign reset_out_o       = 1'b0;
  // open drain reset pulls low while failing or recovering
  assign reset_out_oe_n_o  = !(r.fail_seen || fail);

  property p_no_drive_deselected;
    @(posedge clock_i) disable iff (!rst_n)
      r.sel_s[1] |=> byte_lines_oe_n_o;
  endproperty
  a_no_drive_deselected: assert property (p_no_drive_deselected)
    else $error("byte lines driven while deselected");

  property p_no_write_on_fail;
    @(posedge clock_i) disable iff (!rst_n)
      r.fail_s[1] |-> !do_write;
  endproperty
  a_no_write_on_fail: assert property (p_no_write_on_fail)
    else $error("write during supply fail");

  property p_reset_holds;
    @(posedge clock_i) disable iff (!rst_n)
      $fell(r.fail_s[1]) |-> !reset_out_oe_n_o [*8];
  endproperty
  a_reset_holds: assert property (p_reset_holds)
    else $error("reset released too early");

  property p_undef_before_access;
    @(posedge clock_i) disable iff (!rst_n)
      (r.a_cnt == 8'h00 && r.h_cnt == 8'h00 && !addr_moved) |=>
        byte_lines_o == UNDEF;
  endproperty
  a_undef_before_access: assert property (p_undef_before_access)
    else $error("data shown before access time");

  property p_hold_old;
    @(posedge clock_i) disable iff (!rst_n)
      addr_moved |=> ##1 byte_lines_o == $past(r.old_data);
  endproperty
  a_hold_old: assert property (p_hold_old)
    else $error("old data not held");

  property p_simul_fall;
    @(posedge clock_i) disable iff (!rst_n)
      wr_fall_with_sel |=> (byte_lines_oe_n_o throughout (!r.sel_s[1])[*3]);
  endproperty
  a_simul_fall: assert property (p_simul_fall)
    else $error("outputs driven in simultaneous write");

  property p_read_when;
    @(posedge clock_i) disable iff (!rst_n)
      !byte_lines_oe_n_o |-> $past(r.wr_s[1]) && !$past(r.sel_s[1]);
  endproperty
  a_read_when: assert property (p_read_when)
    else $error("drive without read levels");

  property p_sec_tick;
    @(posedge clock_i) disable iff (!rst_n)
      sec_tick |=> r.sec_cnt == 32'h0 || r.load_pend;
  endproperty
  a_sec_tick: assert property (p_sec_tick)
    else $error("second counter did not wrap");

  property p_backup_counts;
    @(posedge clock_i) disable iff (!rst_n)
      (r.backup_s[1] && !sec_tick && !r.load_pend) |=>
        r.sec_cnt == $past(r.sec_cnt) + 32'h1;
  endproperty
  a_backup_counts: assert property (p_backup_counts)
    else $error("clock stopped on backup");

  property p_fail_deselects;
    @(posedge clock_i) disable iff (!rst_n)
      (fail || r.fail_seen) |=> byte_lines_oe_n_o;
  endproperty
  a_fail_deselects: assert property (p_fail_deselects)
    else $error("byte lines driven during fail or recovery");

  property p_write_lands;
    @(posedge clock_i) disable iff (!rst_n)
      do_write |=> mem[$past(r.addr)] == $past(r.din);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write did not land");

  property p_read_halts;
    @(posedge clock_i) disable iff (!rst_n)
      (ctl[bcs_pkg::CTL_READ_BIT] && !do_write) |=>
        $stable(mem[bcs_pkg::OFS_SECONDS]);
  endproperty
  a_read_halts: assert property (p_read_halts)
    else $error("clock byte refreshed while halted");

  property p_refresh_copies;
    @(posedge clock_i) disable iff (!rst_n)
      (sec_tick && !ctl[bcs_pkg::CTL_WRITE_BIT] &&
       !ctl[bcs_pkg::CTL_READ_BIT] && !do_write) |=>
        mem[bcs_pkg::OFS_MINUTES] == r.ctr.min;
  endproperty
  a_refresh_copies: assert property (p_refresh_copies)
    else $error("clock byte not refreshed from counters");
endmodule : bcs_clock_sram

// *** bcs_host_model.sv ***
// bcs_host_model: host cpu on the asynchronous sram port
// assumes the testbench calls its tasks; shares the device clock
`timescale 1ns/1ps
module bcs_host_model (
  input  wire logic        clock_i,
  input  wire logic [7:0]  bus_i,
  input  wire logic        bus_oe_n_i,
  output logic [12:0]      location_o,
  output logic [7:0]       data_o,
  output logic             select_n_o,
  output logic             drive_n_o,
  output logic             write_n_o
);
  initial begin
    location_o = 13'h0000;
    data_o     = 8'hFF;
    select_n_o = 1'b1;
    drive_n_o  = 1'b1;
    write_n_o  = 1'b1;
  end

  // address held through the overlap and after it
  task automatic bus_write(input logic [12:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    location_o = a;
    data_o     = d;
    drive_n_o  = 1'b1;
    select_n_o = 1'b0;
    write_n_o  = 1'b0;
    repeat (5) @(posedge clock_i);
    #1 write_n_o = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 select_n_o = 1'b1;
    // released line shows no stale value
    data_o = ~d;
  endtask : bus_write

  task automatic bus_read(input logic [12:0] a, input logic sel_n,
                          input logic drv_n, output logic [7:0] d,
                          output logic oe_n);
    @(posedge clock_i) #1;
    location_o = a;
    write_n_o  = 1'b1;
    select_n_o = sel_n;
    drive_n_o  = drv_n;
    repeat (16) @(posedge clock_i);
    d    = bus_i;
    oe_n = bus_oe_n_i;
    #1 select_n_o = 1'b1;
    drive_n_o = 1'b1;
  endtask : bus_read
endmodule : bcs_host_model

// *** bcs_testbench.sv ***
// testbench: self-checking bench for the bcd clock sram port
// assumes short recovery and second counts set by parameter
`timescale 1ns/1ps
module testbench;
  localparam int REC = 20;
  localparam int SEC = 50;
  logic        clock_i;
  logic        reset_n_i;
  logic        fail;
  logic        backup;
  logic [12:0] loc;
  logic [7:0]  host_d;
  logic [7:0]  dev_d;
  logic [7:0]  wire_d;
  logic [7:0]  rd;
  logic        dev_oe_n;
  logic        sel_n;
  logic        drv_n;
  logic        wr_n;
  logic        rst_oe_n;
  logic        oe;
  int          err_total;
  int          n_tests;

  assign wire_d = dev_oe_n ? host_d : dev_d;

  bcs_clock_sram #(.RECOVERY_CYC(REC), .SECOND_CYC(SEC)) i_bcs_clock_sram (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .location_lines_i(loc),
    .byte_lines_i(wire_d), .byte_lines_o(dev_d),
    .byte_lines_oe_n_o(dev_oe_n), .select_n_i(sel_n), .drive_n_i(drv_n),
    .write_n_i(wr_n), .supply_fail_i(fail), .on_backup_i(backup),
    .reset_out_o(), .reset_out_oe_n_o(rst_oe_n));

  bcs_host_model u_host (
    .clock_i(clock_i), .bus_i(wire_d), .bus_oe_n_i(dev_oe_n),
    .location_o(loc), .data_o(host_d), .select_n_o(sel_n),
    .drive_n_o(drv_n), .write_n_o(wr_n));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_recovery();
    int n;
    n = 0;
    @(posedge clock_i) #1;
    chk1("reset held", 1'b0, rst_oe_n);
    while (rst_oe_n !== 1'b1 && n < 100) begin
      @(posedge clock_i) #1;
      n++;
    end
    chk1("reset length", 1'b1, n >= REC && n <= REC + 6);
    // a reset output that never releases ends the run here
    if (rst_oe_n !== 1'b1) report_and_stop();
  endtask : t_recovery

  task automatic t_memory();
    logic [12:0] a [4];
    logic [7:0]  d [4];
    a = '{13'h0000, 13'h0ABC, 13'h1ABC, 13'h1FF7};
    d = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
    for (int i = 0; i < 4; i++) u_host.bus_write(a[i], d[i]);
    for (int i = 0; i < 4; i++) begin
      u_host.bus_read(a[i], 1'b0, 1'b0, rd, oe);
      chk8("mem data", d[i], rd);
      chk1("mem drive", 1'b0, oe);
    end
    u_host.bus_read(13'h0ABC, 1'b1, 1'b0, rd, oe);
    chk1("deselected", 1'b1, oe);
    u_host.bus_read(13'h0ABC, 1'b0, 1'b1, rd, oe);
    chk1("no drive", 1'b1, oe);
  endtask : t_memory

  task automatic t_fail();
    @(posedge clock_i) #1;
    fail   = 1'b1;
    backup = 1'b1;
    u_host.bus_write(13'h0ABC, 8'h00);
    chk1("fail reset", 1'b0, rst_oe_n);
    fail   = 1'b0;
    backup = 1'b0;
    t_recovery();
    u_host.bus_read(13'h0ABC, 1'b0, 1'b0, rd, oe);
    chk8("kept data", 8'hA5, rd);
  endtask : t_fail

  task automatic t_roll(input logic [7:0] yr, input logic [7:0] mo,
                        input logic [7:0] dt, input logic [7:0] e_yr,
                        input logic [7:0] e_mo, input logic [7:0] e_dt);
    logic [7:0] w [7];
    logic [7:0] e [7];
    w = '{8'h59, 8'h59, 8'h23, 8'h01, dt, mo, yr};
    e = '{8'h00, 8'h00, 8'h00, 8'h02, e_dt, e_mo, e_yr};
    u_host.bus_write(bcs_pkg::OFS_CONTROL, 8'h80);
    for (int i = 0; i < 7; i++)
      u_host.bus_write(bcs_pkg::OFS_SECONDS + 13'(i), w[i]);
    u_host.bus_write(bcs_pkg::OFS_CONTROL, 8'h00);
    repeat (55) @(posedge clock_i);
    u_host.bus_write(bcs_pkg::OFS_CONTROL, 8'h40);
    for (int i = 0; i < 7; i++) begin
      u_host.bus_read(bcs_pkg::OFS_SECONDS + 13'(i), 1'b0, 1'b0,
                      rd, oe);
      chk8("time byte", e[i], rd);
    end
    repeat (150) @(posedge clock_i);
    u_host.bus_read(bcs_pkg::OFS_SECONDS, 1'b0, 1'b0, rd, oe);
    chk8("halted sec", 8'h00, rd);
    u_host.bus_read(bcs_pkg::OFS_CONTROL, 1'b0, 1'b0, rd, oe);
    chk8("control", 8'h40, rd);
    u_host.bus_write(bcs_pkg::OFS_CONTROL, 8'h00);
  endtask : t_roll

  initial begin
    reset_n_i = 1'b0;
    fail      = 1'b0;
    backup    = 1'b0;
    err_total = 0;
    n_tests   = 0;
    repeat (16) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    t_recovery();
    t_memory();
    t_roll(8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01);
    t_roll(8'h04, 8'h02, 8'h28, 8'h04, 8'h02, 8'h29);
    t_roll(8'h21, 8'h04, 8'h30, 8'h21, 8'h05, 8'h01);
    t_roll(8'h99, 8'h12, 8'h31, 8'h00, 8'h01, 8'h01);
    // fail after the rolls: control byte known while on backup
    t_fail();
    report_and_stop();
  end
endmodule : testbench
